// >>> design/brte_pkg.sv
/*
 * Shared constants for the boundary run test engine: register map, pin scan
 * chain layout, instruction codes, operation codes and test port states.
 * Assumes a single 10 MHz system clock and a software-visible register bus.
 */
package brte_pkg;

    // ************************************************************
    // Register map (byte addresses on the AHB-Lite bus)
    // ************************************************************
    localparam logic [7:0] ADDR_INSTR = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_CHAIN_LO = 8'h08;
    localparam logic [7:0] ADDR_CHAIN_HI = 8'h0C;
    localparam logic [7:0] ADDR_SHADOW_LO = 8'h10;
    localparam logic [7:0] ADDR_SHADOW_HI = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;

    // Reset values
    localparam logic [7:0] INSTR_RST = 8'hFF;
    localparam logic [2:0] CTRL_RST = 3'h0;

    // ************************************************************
    // Instruction codes
    // ************************************************************
    localparam logic [7:0] INSTR_RUN_TEST = 8'h09;
    localparam logic [7:0] INSTR_READBACK_NORMAL = 8'h0A;
    localparam logic [7:0] INSTR_READBACK_TEST = 8'h8B;
    localparam logic [7:0] INSTR_CTRL_SCAN_NORMAL = 8'h8E;
    localparam logic [7:0] INSTR_CTRL_SCAN_TEST = 8'h0F;

    // ************************************************************
    // Pin scan chain layout
    // ************************************************************
    localparam int CHAIN_W = 48;
    localparam int HALF_W = 18;
    localparam int CTRL_W = 3;
    localparam int B_LSB = 0;
    localparam int A_LSB = 18;
    localparam int BIT_B1_FWD_N = 47;
    localparam int BIT_B2_FWD_N = 46;
    localparam int BIT_B1_REV_N = 45;
    localparam int BIT_B2_REV_N = 44;
    localparam int BYTE_W = 9;

    // Maximal-length feedback polynomials x^36+x^25+1 and x^18+x^11+1
    localparam int TAP36 = 25;
    localparam int TAP18 = 11;

    // ************************************************************
    // Operation codes held in the test control chain
    // ************************************************************
    localparam logic [1:0] OPLO_TOGGLE = 2'h0;
    localparam logic [1:0] OPLO_PATTERN = 2'h1;
    localparam logic [1:0] OPLO_SIGNATURE = 2'h2;

    typedef enum {
        OP_SAMPLE_TOGGLE, OP_PATTERN36, OP_SIGNATURE36, OP_SIG_PATTERN, OP_SIG_COUNT
    } brte_op_t;

    typedef enum {
        TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SHIFT_DR, TS_EXIT1_DR, TS_PAUSE_DR,
        TS_EXIT2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SHIFT_IR, TS_EXIT1_IR,
        TS_PAUSE_IR, TS_EXIT2_IR, TS_UPD_IR
    } brte_tap_t;

    localparam logic [3:0] TS_CODE_IDLE = 4'h1;

endpackage

// >>> design/brte_tap.sv
/*
 * Test port state follower. Advances one step per rising test clock edge,
 * as reported by the caller's edge pulse. Assumes the mode select input is
 * already synchronised to the system clock.
 */
`timescale 1ns/1ps
module brte_tap
    import brte_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Test port
    input wire logic tck_rise,
    input wire logic tms,
    // State
    output brte_tap_t state
);

    brte_tap_t state_q, state_d;

    assign state = state_q;

    // Standard sixteen-state walk driven by the mode select
    always_comb begin
        state_d = state_q;
        case (state_q)
            TS_RESET: state_d = tms ? TS_RESET : TS_IDLE;
            TS_IDLE: state_d = tms ? TS_SEL_DR : TS_IDLE;
            TS_SEL_DR: state_d = tms ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR: state_d = tms ? TS_EXIT1_DR : TS_SHIFT_DR;
            TS_SHIFT_DR: state_d = tms ? TS_EXIT1_DR : TS_SHIFT_DR;
            TS_EXIT1_DR: state_d = tms ? TS_UPD_DR : TS_PAUSE_DR;
            TS_PAUSE_DR: state_d = tms ? TS_EXIT2_DR : TS_PAUSE_DR;
            TS_EXIT2_DR: state_d = tms ? TS_UPD_DR : TS_SHIFT_DR;
            TS_UPD_DR: state_d = tms ? TS_SEL_DR : TS_IDLE;
            TS_SEL_IR: state_d = tms ? TS_RESET : TS_CAP_IR;
            TS_CAP_IR: state_d = tms ? TS_EXIT1_IR : TS_SHIFT_IR;
            TS_SHIFT_IR: state_d = tms ? TS_EXIT1_IR : TS_SHIFT_IR;
            TS_EXIT1_IR: state_d = tms ? TS_UPD_IR : TS_PAUSE_IR;
            TS_PAUSE_IR: state_d = tms ? TS_EXIT2_IR : TS_PAUSE_IR;
            TS_EXIT2_IR: state_d = tms ? TS_UPD_IR : TS_SHIFT_IR;
            TS_UPD_IR: state_d = tms ? TS_SEL_DR : TS_IDLE;
            default: state_d = TS_RESET;
        endcase
    end

    // Only a test clock rising edge moves the state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= TS_RESET;
        end else if (tck_rise) begin
            state_q <= state_d;
        end
    end

endmodule

// >>> design/brte_top.sv
/*
 * Boundary run test engine of an 18-bit scan-testable bus transceiver.
 * Holds the pin scan chain and its shadow latches, the test control chain,
 * and runs the five built-in test operations in Run-Test/Idle.
 * Assumes an AHB-Lite master on CLK_SYS and a test controller whose test
 * clock is far slower than CLK_SYS; all pins are sampled by two flip-flops.
 */
// The implementer's own choices: the AHB-Lite register port and the register offsets.
// Contract
// [RULE_01] Opcode comes from control chain bits 2..0.
// [RULE_02] Run only under run instruction in Run-Test/Idle.
// [RULE_03] X00 toggle, X01 pattern36, X10 signature36.
// [RULE_04] 011 signature+pattern, 111 signature+count.
// [RULE_05] Control cells 47..36 excluded from algorithms.
// [RULE_06] Enable cells 47..44 still gate pin drive.
// [RULE_07] Need valid, matching byte directions, else bypass.
// [RULE_08] Toggle mode samples input pins each rise.
// [RULE_09] Toggle inverts outputs on rise, drives on fall.
// [RULE_10] Pattern36 steps LFSR on rise, drives on fall.
// [RULE_11] Controller should seed chain before running.
// [RULE_12] All-zero seed locks the pattern generators.
// [RULE_13] Signature36 folds input pins each rise.
// [RULE_14] Signature36 keeps output shadows unchanged.
// [RULE_15] Combined modes build 18-bit input signature.
// [RULE_16] Signature+pattern steps 18-bit generator outputs.
// [RULE_17] Signature+count increments 18-bit output counter.
// [RULE_18] Run instruction selects bypass bit, captures zero.
// [RULE_19] Controller loads control chain before run.
// [RULE_20] Readback selects pin chain, capture keeps it.
// [RULE_21] Maximal-length taps chosen per mode, direction.
// [RULE_22] Input and output roles follow flow direction.
`timescale 1ns/1ps
module brte_top
    import brte_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic NRST,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Test port pins
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    output logic TDO,
    output logic TDO_OE,
    // Transceiver I/O pins, split into input, output and enable
    input wire logic [17:0] A_IN,
    output logic [17:0] A_OUT,
    output logic [17:0] A_OE,
    input wire logic [17:0] B_IN,
    output logic [17:0] B_OUT,
    output logic [17:0] B_OE
);

    // ************************************************************
    // Functions
    // ************************************************************

    // One step of the 36-bit Fibonacci register, x^36+x^25+1
    function automatic logic [35:0] step36(input logic [35:0] s);
        step36 = {s[34:0], s[35] ^ s[TAP36-1]}; // see [RULE_21]
    endfunction

    // One step of the 18-bit register, x^18+x^11+1
    function automatic logic [17:0] step18(input logic [17:0] s);
        step18 = {s[16:0], s[17] ^ s[TAP18-1]}; // see [RULE_21]
    endfunction

    // ************************************************************
    // Pin synchronisers and test clock edges
    // ************************************************************
    logic tck_s1_q, tck_s2_q, tck_s3_q;
    logic tms_s1_q, tms_s2_q, tdi_s1_q, tdi_s2_q;
    logic [17:0] a_s1_q, a_s2_q, b_s1_q, b_s2_q;
    logic tck_rise, tck_fall;

    // Two stages before anything looks at a pin; the third feeds edge finding
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            {tck_s1_q, tck_s2_q, tck_s3_q} <= 3'h0;
            {tms_s1_q, tms_s2_q, tdi_s1_q, tdi_s2_q} <= 4'hF;
            {a_s1_q, a_s2_q, b_s1_q, b_s2_q} <= 72'h0;
        end else begin
            tck_s1_q <= TCK;
            tck_s2_q <= tck_s1_q;
            tck_s3_q <= tck_s2_q;
            tms_s1_q <= TMS;
            tms_s2_q <= tms_s1_q;
            tdi_s1_q <= TDI;
            tdi_s2_q <= tdi_s1_q;
            a_s1_q <= A_IN;
            a_s2_q <= a_s1_q;
            b_s1_q <= B_IN;
            b_s2_q <= b_s1_q;
        end
    end

    assign tck_rise = tck_s2_q & ~tck_s3_q;
    assign tck_fall = ~tck_s2_q & tck_s3_q;

    brte_tap_t tap;

    brte_tap u_tap (
        .clk(CLK_SYS),
        .rst_n(NRST),
        .tck_rise(tck_rise),
        .tms(tms_s2_q),
        .state(tap)
    );

    // ************************************************************
    // Register bus slave
    // ************************************************************
    logic dp_wr_q;
    logic [7:0] dp_addr_q;
    logic [7:0] instr_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [CHAIN_W-1:0] chain_q;
    logic [35:0] shadow_q;
    logic [31:0] hrdata_q;
    logic addr_ok, wr_chain_lo, wr_chain_hi;
    logic run_ok, dir_ok, fwd, test_mode, rb_sel, cs_sel;

    assign addr_ok = HSEL & HREADY & HTRANS[1];
    assign wr_chain_lo = dp_wr_q && dp_addr_q == ADDR_CHAIN_LO;
    assign wr_chain_hi = dp_wr_q && dp_addr_q == ADDR_CHAIN_HI;

    // Capture the write address phase; the data follows one cycle later
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            dp_wr_q <= 1'b0;
            dp_addr_q <= 8'h00;
        end else begin
            dp_wr_q <= addr_ok & HWRITE;
            dp_addr_q <= HADDR[7:0];
        end
    end

    // Read data is chosen in the address phase so no wait state is needed
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            hrdata_q <= 32'h0;
        end else if (addr_ok && !HWRITE) begin
            case (HADDR[7:0])
                ADDR_INSTR: hrdata_q <= {24'h0, instr_q};
                ADDR_CTRL: hrdata_q <= {29'h0, ctrl_q};
                ADDR_CHAIN_LO: hrdata_q <= chain_q[31:0];
                ADDR_CHAIN_HI: hrdata_q <= {16'h0, chain_q[47:32]};
                ADDR_SHADOW_LO: hrdata_q <= shadow_q[31:0];
                ADDR_SHADOW_HI: hrdata_q <= {28'h0, shadow_q[35:32]};
                ADDR_STATUS: hrdata_q <= {25'h0, fwd, dir_ok, run_ok, 4'(tap)};
                default: hrdata_q <= 32'h0;
            endcase
        end
    end

    // Always ready, always OKAY
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    assign HRDATA = hrdata_q;

    // Active instruction; the Test-Logic-Reset state falls back to bypass
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            instr_q <= INSTR_RST;
        end else if (dp_wr_q && dp_addr_q == ADDR_INSTR) begin
            instr_q <= HWDATA[7:0];
        end else if (tap == TS_RESET) begin
            instr_q <= INSTR_RST;
        end
    end

    // ************************************************************
    // Mode decode
    // ************************************************************
    brte_op_t op;
    logic [17:0] in_h, out_h, pins, in_nx, out_nx;

    // Bit 2 only matters when the low bits are both one
    always_comb begin
        case (ctrl_q[1:0]) // see [RULE_01]
            OPLO_TOGGLE: op = OP_SAMPLE_TOGGLE; // see [RULE_03]
            OPLO_PATTERN: op = OP_PATTERN36;
            OPLO_SIGNATURE: op = OP_SIGNATURE36;
            default: op = ctrl_q[2] ? OP_SIG_COUNT : OP_SIG_PATTERN; // see [RULE_04]
        endcase
    end

    // Each byte must have exactly one enable active and both must agree
    assign dir_ok = (chain_q[BIT_B1_FWD_N] != chain_q[BIT_B1_REV_N])
        && (chain_q[BIT_B2_FWD_N] != chain_q[BIT_B2_REV_N])
        && (chain_q[BIT_B1_FWD_N] == chain_q[BIT_B2_FWD_N]); // see [RULE_07]
    assign fwd = ~chain_q[BIT_B1_FWD_N];
    assign run_ok = instr_q == INSTR_RUN_TEST && tap == TS_IDLE && dir_ok; // see [RULE_02]
    assign rb_sel = instr_q == INSTR_READBACK_NORMAL || instr_q == INSTR_READBACK_TEST;
    assign cs_sel = instr_q == INSTR_CTRL_SCAN_NORMAL || instr_q == INSTR_CTRL_SCAN_TEST;
    assign test_mode = (instr_q == INSTR_RUN_TEST && dir_ok) || instr_q == INSTR_READBACK_TEST
        || instr_q == INSTR_CTRL_SCAN_TEST;

    // Input and output halves swap with the flow direction
    assign in_h = fwd ? chain_q[A_LSB +: HALF_W] : chain_q[B_LSB +: HALF_W]; // see [RULE_22]
    assign out_h = fwd ? chain_q[B_LSB +: HALF_W] : chain_q[A_LSB +: HALF_W];
    assign pins = fwd ? a_s2_q : b_s2_q;

    // Next value of the data cells; control cells never enter here
    always_comb begin
        in_nx = in_h;
        out_nx = out_h;
        case (op)
            OP_SAMPLE_TOGGLE: begin
                in_nx = pins; // see [RULE_08]
                out_nx = ~out_h; // see [RULE_09]
            end
            OP_PATTERN36: begin
                {out_nx, in_nx} = step36({out_h, in_h}); // see [RULE_10] [RULE_12]
            end
            OP_SIGNATURE36: begin
                {out_nx, in_nx} = step36({out_h, in_h}) ^ {18'h0, pins}; // see [RULE_13]
            end
            OP_SIG_PATTERN: begin
                in_nx = step18(in_h) ^ pins; // see [RULE_15]
                out_nx = step18(out_h); // see [RULE_16] [RULE_12]
            end
            OP_SIG_COUNT: begin
                in_nx = step18(in_h) ^ pins; // see [RULE_15]
                out_nx = out_h + 18'h1; // see [RULE_17]
            end
            default: begin
                in_nx = in_h;
                out_nx = out_h;
            end
        endcase
    end

    // ************************************************************
    // Scan chains
    // ************************************************************

    // Pin scan chain: run steps, readback shifting, then software writes
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            chain_q <= {4'hF, 44'h0};
        end else begin
            if (tck_rise && run_ok) begin
                if (fwd) begin
                    chain_q[35:0] <= {in_nx, out_nx}; // see [RULE_05]
                end else begin
                    chain_q[35:0] <= {out_nx, in_nx};
                end
            end else if (tck_rise && rb_sel && tap == TS_SHIFT_DR) begin
                chain_q <= {tdi_s2_q, chain_q[47:1]}; // see [RULE_20]
            end
            if (wr_chain_lo) begin
                chain_q[31:0] <= HWDATA;
            end
            if (wr_chain_hi) begin
                chain_q[47:32] <= HWDATA[15:0];
            end
        end
    end

    // Test control chain; its capture leaves it alone
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            ctrl_q <= CTRL_RST;
        end else if (dp_wr_q && dp_addr_q == ADDR_CTRL) begin
            ctrl_q <= HWDATA[CTRL_W-1:0];
        end else if (tck_rise && cs_sel && tap == TS_SHIFT_DR) begin
            ctrl_q <= {tdi_s2_q, ctrl_q[CTRL_W-1:1]}; // see [RULE_19]
        end
    end

    // Bypass bit is cleared on capture and shifts in Shift-DR
    logic bypass_q;

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            bypass_q <= 1'b0;
        end else if (tck_rise && !rb_sel && !cs_sel) begin
            if (tap == TS_CAP_DR) begin
                bypass_q <= 1'b0; // see [RULE_18]
            end else if (tap == TS_SHIFT_DR) begin
                bypass_q <= tdi_s2_q;
            end
        end
    end

    // Serial out changes on the falling test clock edge
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            TDO <= 1'b0;
            TDO_OE <= 1'b0;
        end else if (tck_fall) begin
            TDO_OE <= tap == TS_SHIFT_DR;
            TDO <= rb_sel ? chain_q[0] : (cs_sel ? ctrl_q[0] : bypass_q);
        end
    end

    // ************************************************************
    // Shadow latches and pin drive
    // ************************************************************

    // Output half is copied on the falling edge except in Signature36 mode
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            shadow_q <= 36'h0;
        end else if (tck_fall && run_ok && op != OP_SIGNATURE36) begin // see [RULE_14]
            if (fwd) begin
                shadow_q[B_LSB +: HALF_W] <= chain_q[B_LSB +: HALF_W]; // see [RULE_09]
            end else begin
                shadow_q[A_LSB +: HALF_W] <= chain_q[A_LSB +: HALF_W];
            end
        end
    end

    // Pins follow the shadows; enables come from the enable cells
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            A_OUT <= 18'h0;
            B_OUT <= 18'h0;
            A_OE <= 18'h0;
            B_OE <= 18'h0;
        end else begin
            A_OUT <= shadow_q[A_LSB +: HALF_W];
            B_OUT <= shadow_q[B_LSB +: HALF_W];
            A_OE <= {{BYTE_W{test_mode & ~chain_q[BIT_B2_REV_N]}},
                {BYTE_W{test_mode & ~chain_q[BIT_B1_REV_N]}}}; // see [RULE_06]
            B_OE <= {{BYTE_W{test_mode & ~chain_q[BIT_B2_FWD_N]}},
                {BYTE_W{test_mode & ~chain_q[BIT_B1_FWD_N]}}};
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);

    logic wr_any;
    assign wr_any = wr_chain_lo | wr_chain_hi;

    sequence s_run_rise(brte_op_t m);
        run_ok && tck_rise && op == m && !wr_any;
    endsequence

    sequence s_run_fall;
        run_ok && tck_fall && op != OP_SIGNATURE36 && fwd;
    endsequence

    a_toggle_outputs: assert property (s_run_rise(OP_SAMPLE_TOGGLE) |=> // see [RULE_09]
        (fwd ? chain_q[17:0] : chain_q[35:18]) == ~$past(out_h))
        else $error("toggle mode did not invert output cells");

    a_count_step: assert property (s_run_rise(OP_SIG_COUNT) |=> // see [RULE_17]
        (fwd ? chain_q[17:0] : chain_q[35:18]) == $past(out_h) + 18'h1)
        else $error("count mode did not increment by one");

    a_zero_lock: assert property (s_run_rise(OP_PATTERN36) && chain_q[35:0] == 36'h0 // see [RULE_12]
        |=> chain_q[35:0] == 36'h0)
        else $error("zero seed produced a pattern");

    a_ctrl_cells_kept: assert property (run_ok && tck_rise && !wr_chain_hi // see [RULE_05]
        |=> $stable(chain_q[47:36]))
        else $error("control cells changed during a run");

    a_sig_shadow_hold: assert property (run_ok && op == OP_SIGNATURE36 // see [RULE_14]
        |=> $stable(shadow_q))
        else $error("shadow changed in signature mode");

    a_drive_after_fall: assert property (s_run_fall ##2 1'b1 |-> // see [RULE_10]
        B_OUT == $past(chain_q[17:0], 2))
        else $error("pins do not show the latched state");

    a_idle_gate: assert property (instr_q == INSTR_RUN_TEST && tap != TS_IDLE // see [RULE_02]
        && tck_rise && !wr_any |=> $stable(chain_q))
        else $error("operation ran outside Run-Test/Idle");

    a_bad_dir_gate: assert property (!dir_ok && tck_rise && !rb_sel && !wr_any // see [RULE_07]
        |=> $stable(chain_q))
        else $error("operation ran with invalid direction");

    a_bypass_capture: assert property (instr_q == INSTR_RUN_TEST && tap == TS_CAP_DR // see [RULE_18]
        && tck_rise |=> !bypass_q)
        else $error("bypass bit did not capture zero");

    a_enable_gate: assert property (test_mode && chain_q[BIT_B1_FWD_N] // see [RULE_06]
        |=> B_OE[8:0] == 9'h0)
        else $error("byte one driven while its enable is off");

endmodule

// >>> dv/brte_ctl_model.sv
/* Test controller model: drives test clock, mode select and data in.
   Assumes the engine finds test clock edges on its own system clock. */
`timescale 1ns/1ps
module brte_ctl_model (
    // Test port
    output logic tck,
    output logic tms,
    output logic tdi
);
    // Clock parks low between bursts, so no stray edges reach the engine
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One 800 ns cycle per step; mode select moves only while the clock is low
    task automatic step(input logic m, input int n);
        #37;
        for (int k = 0; k < n; k++) begin
            tms = m;
            #400 tck = 1'b1;
            #400 tck = 1'b0;
        end
    endtask
endmodule

// >>> dv/brte_top_tb.sv
/* Self-checking bench for the boundary run test engine.
   Assumes registers on AHB-Lite and a controller model on the test port. */
`timescale 1ns/1ps
module brte_top_tb;
    import brte_pkg::*;
    logic clk_sys, nrst, hsel, hwrite, hreadyout, hresp, tck, tms, tdi;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [17:0] a_in, a_out, a_oe, b_in, b_out, b_oe;
    int mismatches, checks_done, cycles;
    brte_top brte_top_i (.CLK_SYS(clk_sys), .NRST(nrst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .TCK(tck), .TMS(tms),
        .TDI(tdi), .TDO(), .TDO_OE(), .A_IN(a_in), .A_OUT(a_out), .A_OE(a_oe),
        .B_IN(b_in), .B_OUT(b_out), .B_OE(b_oe));
    brte_ctl_model brte_ctl_model_i (.tck(tck), .tms(tms), .tdi(tdi));
    // Clock; a hang is cut short by a cycle ceiling
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end
    // Counts then verdict
    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task chk(input logic [47:0] got, input logic [47:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Single word transfer; waits on ready, data taken at the data phase edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // Expected chain, forward flow: B cells drive, A cells sample
    function logic [47:0] model(input logic [2:0] op, input logic [47:0] c, input int n,
                                input logic [17:0] ain);
        logic [17:0] o;
        logic [17:0] i;
        logic [35:0] s;
        o = c[17:0];
        i = c[35:18];
        for (int k = 0; k < n; k++) begin
            s = {o, i};
            if (op[1:0] == 2'h0) begin
                o = ~o;
                i = ain;
            end else if (op[1:0] == 2'h1) begin
                {o, i} = {s[34:0], s[35] ^ s[24]};
            end else if (op == 3'h3) begin
                o = {o[16:0], o[17] ^ o[10]};
            end else if (op == 3'h7) begin
                o = o + 18'h1;
            end
        end
        return {c[47:36], i, o};
    endfunction
    // Fresh reset, seed, opcode, run n steps in idle, read the chain back
    task scen(input logic [2:0] op, input logic [47:0] seed, input int n,
              input logic [17:0] ain, input logic [7:0] ins);
        logic [31:0] r;
        logic [47:0] ch;
        logic [47:0] exp;
        logic go;
        go = (ins == INSTR_RUN_TEST) && (seed[47:44] == 4'h3);
        exp = go ? model(op, seed, n, ain) : seed;
        @(posedge clk_sys);
        nrst <= 1'b0;
        a_in <= ain;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        bus(1'b1, ADDR_CHAIN_LO, seed[31:0], r);
        bus(1'b1, ADDR_CHAIN_HI, {16'h0, seed[47:32]}, r);
        bus(1'b1, ADDR_CTRL, {29'h0, op}, r);
        brte_ctl_model_i.step(1'b0, 1);
        bus(1'b1, ADDR_INSTR, {24'h0, ins}, r);
        brte_ctl_model_i.step(1'b0, n);
        repeat (10) @(posedge clk_sys);
        bus(1'b0, ADDR_CHAIN_LO, 32'h0, r);
        ch[31:0] = r;
        bus(1'b0, ADDR_CHAIN_HI, 32'h0, r);
        ch[47:32] = r[15:0];
        if (op[1:0] == 2'h2) begin
            chk(48'(ch[47:36]), 48'(seed[47:36]));
            exp[17:0] = 18'h0;
        end else begin
            chk(ch, exp);
        end
        if (!go) exp[17:0] = 18'h0;
        chk(48'(b_out), 48'(exp[17:0]));
        chk(48'({a_oe, b_oe}), go ? 48'h3FFFF : 48'h0);
        chk(48'({a_out, hresp}), 48'h0);
    endtask
    // Main sequence; reset, then a run of each operation plus zero-seed, bad-direction and bypass runs
    initial begin
        {nrst, hsel, hwrite, htrans, haddr, hwdata, a_in, b_in} = '0;
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        scen(3'h4, 48'h3A5123456789, 3, 18'h2A5A5, INSTR_RUN_TEST);
        scen(3'h1, 48'h3A5123456789, 5, 18'h0, INSTR_RUN_TEST);
        scen(3'h5, 48'h300000000000, 4, 18'h0, INSTR_RUN_TEST);
        scen(3'h3, 48'h30000002C001, 4, 18'h0, INSTR_RUN_TEST);
        scen(3'h7, 48'h30000003FFFE, 3, 18'h0, INSTR_RUN_TEST);
        scen(3'h2, 48'h3A5123456789, 4, 18'h2A5A5, INSTR_RUN_TEST);
        scen(3'h1, 48'h0A5123456789, 4, 18'h0, INSTR_RUN_TEST);
        scen(3'h1, 48'h3A5123456789, 4, 18'h0, 8'hFF);
        wrap_up();
    end
endmodule
